/* File: inc/bag_pkg.sv */
// Shared constants and types of the bit and I/O address generator
package bag_pkg;
	// ****************************************
	// APB register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_POINTER = 8'h04;
	localparam logic [7:0] OFS_BUF_START = 8'h08;
	localparam logic [7:0] OFS_PAGE = 8'h0c;
	localparam logic [7:0] OFS_ACC_TWO = 8'h10;
	localparam logic [7:0] OFS_ACC_THREE = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_CMD = 8'h1c;
	localparam logic [7:0] OFS_OPERAND = 8'h20;
	localparam logic [7:0] OFS_IO_ADDR = 8'h24;
	localparam logic [7:0] OFS_BIT_ADDR = 8'h28;
	localparam logic [7:0] OFS_IO_DATA = 8'h2c;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int CTRL_CIRC_BIT = 0;
	localparam int STAT_TF1_BIT = 0;
	localparam int STAT_TF2_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;
	localparam int STAT_REFUSED_BIT = 3;
	localparam int PAGE_OFS_BITS = 7;
	localparam logic [22:0] RST_POINTER = 23'h000000;
	localparam logic [15:0] RST_BUF_START = 16'h0000;
	localparam logic [8:0] RST_PAGE = 9'h000;
	localparam logic [31:0] RST_WORD = 32'h00000000;
	localparam logic [22:0] STEP_ONE = 23'h000001;
	localparam logic [22:0] STEP_TWO = 23'h000002;

	// ****************************************
	// Commands and operand modes
	// ****************************************
	typedef enum logic [2:0]
	{
		OP_BIT_SET = 3'h0,
		OP_BIT_CLEAR = 3'h1,
		OP_BIT_PAIR_TEST = 3'h2,
		OP_IO_ABSOLUTE = 3'h3,
		OP_PAGE_DIRECT = 3'h4
	} bag_op_t;

	typedef enum logic [1:0]
	{
		BM_POST_DEC = 2'h0,
		BM_CONST_OFS = 2'h1,
		BM_PRE_ADD = 2'h2
	} bag_mode_t;

	// Command word as written to the command register
	typedef struct packed
	{
		logic xfer_write;
		logic port_qual;
		logic parallel;
		logic acc_sel;
		logic [1:0] mode;
		logic [2:0] op;
	} bag_cmd_t;

	// One-word transfer towards I/O space or data memory
	typedef struct packed
	{
		logic io_req;
		logic mem_req;
		logic write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} bag_xfer_t;
endpackage

/* File: hdl/bag_addr_gen.sv */
// Bit and I/O address generator with APB register access
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// What this block does
// - Post-decrement: use pointer, then subtract 1/2
// - Pair test copies two bits into flags
// - Constant offset sign-extended, pointer kept
// - Pre-add writes sum back, uses sum
// - Sixteen-bit offset forbids parallel execution
// - Absolute I/O constant, never paired
// - Each I/O access moves one word
// - Page-direct address is page then offset
// - Offset 0 first, 127 last word
// - Port qualifier routes to I/O space
// - Direct I/O address wraps at sixteen bits
// - Bit set sets addressed accumulator bit
// - Bit clear clears addressed accumulator bit
module bag_addr_gen
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output bag_pkg::bag_xfer_t xfer,
	input wire logic xfer_ack,
	input wire logic [15:0] xfer_rdata
);
	typedef enum logic {ST_IDLE, ST_XFER} bag_state_t;

	logic circ_enable;
	logic [22:0] coeff_pointer_extended;
	logic [15:0] coeff_buffer_start;
	logic [8:0] peripheral_page_pointer;
	logic [31:0] accumulator_two;
	logic [31:0] accumulator_three;
	logic test_flag_one;
	logic test_flag_two;
	logic refused;
	bag_pkg::bag_cmd_t cmd;
	logic [15:0] operand;
	logic [15:0] io_data;
	logic [22:0] bit_addr;
	logic go;
	bag_state_t state;
	logic wr_en;
	logic rd_hit;
	logic uses_k16;
	logic bad;
	logic exec;
	logic is_bit_op;
	logic pair;
	logic [22:0] off23;
	logic [22:0] sum23;
	logic [22:0] next_bit_addr;
	logic [4:0] bit_idx;
	logic [4:0] bit_idx2;
	logic [31:0] acc_sel_val;
	logic [15:0] next_xfer_addr;

	// ****************************************
	// APB slave
	// ****************************************
	assign wr_en = psel && penable && pwrite;
	assign pready = 1'b1;
	assign rd_hit = (paddr[1:0] == 2'h0) && (paddr <= bag_pkg::OFS_IO_DATA);
	assign pslverr = psel && penable && !rd_hit;

	// Read mux; unmapped words read zero
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			prdata <= bag_pkg::RST_WORD;
		else if (psel && !penable && !pwrite)
		begin
			unique case (paddr)
				bag_pkg::OFS_CTRL: prdata <= {31'h0, circ_enable};
				bag_pkg::OFS_POINTER: prdata <= {9'h0, coeff_pointer_extended};
				bag_pkg::OFS_BUF_START: prdata <= {16'h0, coeff_buffer_start};
				bag_pkg::OFS_PAGE: prdata <= {23'h0, peripheral_page_pointer};
				bag_pkg::OFS_ACC_TWO: prdata <= accumulator_two;
				bag_pkg::OFS_ACC_THREE: prdata <= accumulator_three;
				bag_pkg::OFS_STATUS: prdata <= {28'h0, refused, go || state == ST_XFER, test_flag_two, test_flag_one};
				bag_pkg::OFS_CMD: prdata <= {23'h0, cmd};
				bag_pkg::OFS_OPERAND: prdata <= {16'h0, operand};
				bag_pkg::OFS_IO_ADDR: prdata <= {16'h0, xfer.addr};
				bag_pkg::OFS_BIT_ADDR: prdata <= {9'h0, bit_addr};
				bag_pkg::OFS_IO_DATA: prdata <= {16'h0, io_data};
				default: prdata <= bag_pkg::RST_WORD;
			endcase
		end
	end

	// Plain configuration registers
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			circ_enable <= 1'b0;
			coeff_buffer_start <= bag_pkg::RST_BUF_START;
			peripheral_page_pointer <= bag_pkg::RST_PAGE;
			operand <= 16'h0000;
		end
		else if (wr_en)
		begin
			if (paddr == bag_pkg::OFS_CTRL)
				circ_enable <= pwdata[bag_pkg::CTRL_CIRC_BIT];
			if (paddr == bag_pkg::OFS_BUF_START)
				coeff_buffer_start <= pwdata[15:0];
			if (paddr == bag_pkg::OFS_PAGE)
				peripheral_page_pointer <= pwdata[8:0];
			if (paddr == bag_pkg::OFS_OPERAND)
				operand <= pwdata[15:0];
		end
	end

	// Command launch; a command written while busy is dropped without setting the refusal flag
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			cmd <= '0;
			go <= 1'b0;
		end
		else
		begin
			go <= wr_en && paddr == bag_pkg::OFS_CMD && !go && state == ST_IDLE;
			if (wr_en && paddr == bag_pkg::OFS_CMD && !go && state == ST_IDLE)
				cmd <= pwdata[8:0];
		end
	end

	// ****************************************
	// Bit address generation
	// ****************************************
	assign is_bit_op = cmd.op == bag_pkg::OP_BIT_SET || cmd.op == bag_pkg::OP_BIT_CLEAR
		|| cmd.op == bag_pkg::OP_BIT_PAIR_TEST;
	assign pair = cmd.op == bag_pkg::OP_BIT_PAIR_TEST;
	// Offset forms and the absolute constant come from a two-byte extension
	assign uses_k16 = (is_bit_op && cmd.mode != bag_pkg::BM_POST_DEC) || cmd.op == bag_pkg::OP_IO_ABSOLUTE;
	assign bad = (cmd.parallel && uses_k16)
		|| (is_bit_op && cmd.mode > bag_pkg::BM_PRE_ADD) || cmd.op > bag_pkg::OP_PAGE_DIRECT;
	assign exec = go && !bad;
	// Post-decrement uses the pointer itself, the other forms add the signed constant
	assign off23 = (cmd.mode == bag_pkg::BM_POST_DEC) ? 23'h000000 : {{7{operand[15]}}, operand};
	assign sum23 = coeff_pointer_extended + off23;
	// Buffer start joins the low half only in circular mode
	assign next_bit_addr = circ_enable ? {sum23[22:16], coeff_buffer_start + sum23[15:0]} : sum23;
	assign bit_idx = next_bit_addr[4:0];
	assign bit_idx2 = bit_idx + 5'h01;
	assign acc_sel_val = cmd.acc_sel ? accumulator_three : accumulator_two;

	// Pointer update per operand form
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			coeff_pointer_extended <= bag_pkg::RST_POINTER;
		else if (exec && is_bit_op && cmd.mode == bag_pkg::BM_POST_DEC)
			coeff_pointer_extended <= coeff_pointer_extended - (pair ? bag_pkg::STEP_TWO : bag_pkg::STEP_ONE);
		else if (exec && is_bit_op && cmd.mode == bag_pkg::BM_PRE_ADD)
			coeff_pointer_extended <= sum23;
		else if (wr_en && paddr == bag_pkg::OFS_POINTER)
			coeff_pointer_extended <= pwdata[22:0];
	end

	// Last generated bit address, for software to inspect
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			bit_addr <= bag_pkg::RST_POINTER;
		else if (exec && is_bit_op)
			bit_addr <= next_bit_addr;
	end

	// Accumulators; an executing command wins over a bus write
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			accumulator_two <= bag_pkg::RST_WORD;
			accumulator_three <= bag_pkg::RST_WORD;
		end
		else if (exec && (cmd.op == bag_pkg::OP_BIT_SET || cmd.op == bag_pkg::OP_BIT_CLEAR))
		begin
			if (cmd.acc_sel)
				accumulator_three[bit_idx] <= cmd.op == bag_pkg::OP_BIT_SET;
			else
				accumulator_two[bit_idx] <= cmd.op == bag_pkg::OP_BIT_SET;
		end
		else if (wr_en && paddr == bag_pkg::OFS_ACC_TWO)
			accumulator_two <= pwdata;
		else if (wr_en && paddr == bag_pkg::OFS_ACC_THREE)
			accumulator_three <= pwdata;
	end

	// Test flags and sticky refusal flag; a new refusal beats write-one-to-clear
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			test_flag_one <= 1'b0;
			test_flag_two <= 1'b0;
			refused <= 1'b0;
		end
		else
		begin
			if (exec && pair)
			begin
				test_flag_one <= acc_sel_val[bit_idx];
				test_flag_two <= acc_sel_val[bit_idx2];
			end
			if (go && bad)
				refused <= 1'b1;
			else if (wr_en && paddr == bag_pkg::OFS_STATUS && pwdata[bag_pkg::STAT_REFUSED_BIT])
				refused <= 1'b0;
		end
	end

	// ****************************************
	// I/O space and data memory transfers
	// ****************************************
	// Absolute constant used as is; page-direct keeps only sixteen bits so it wraps
	assign next_xfer_addr = (cmd.op == bag_pkg::OP_IO_ABSOLUTE) ? operand
		: {peripheral_page_pointer, operand[bag_pkg::PAGE_OFS_BITS-1:0]};

	// One word per request, held until acknowledged
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			state <= ST_IDLE;
			xfer <= '0;
			io_data <= 16'h0000;
		end
		else
		begin
			unique case (state)
				ST_IDLE:
				begin
					if (exec && !is_bit_op)
					begin
						state <= ST_XFER;
						xfer.io_req <= cmd.op == bag_pkg::OP_IO_ABSOLUTE || cmd.port_qual;
						xfer.mem_req <= cmd.op == bag_pkg::OP_PAGE_DIRECT && !cmd.port_qual;
						xfer.write <= cmd.xfer_write;
						xfer.addr <= next_xfer_addr;
						xfer.wdata <= io_data;
					end
					else if (wr_en && paddr == bag_pkg::OFS_IO_DATA)
						io_data <= pwdata[15:0];
				end
				ST_XFER:
				begin
					if (xfer_ack)
					begin
						state <= ST_IDLE;
						xfer.io_req <= 1'b0;
						xfer.mem_req <= 1'b0;
						if (!xfer.write)
							io_data <= xfer_rdata;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking bag_cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	a_post_dec_step: assert property (exec && is_bit_op && cmd.mode == bag_pkg::BM_POST_DEC |=>
		coeff_pointer_extended == $past(coeff_pointer_extended) - ($past(pair) ? 23'h000002 : 23'h000001))
		else $error("post-decrement step wrong");
	a_pair_flags: assert property (exec && pair |=>
		test_flag_one == $past(acc_sel_val[bit_idx]) && test_flag_two == $past(acc_sel_val[bit_idx2]))
		else $error("pair test flags wrong");
	a_const_keeps_ptr: assert property (exec && is_bit_op && cmd.mode == bag_pkg::BM_CONST_OFS && !circ_enable
		&& !(wr_en && paddr == bag_pkg::OFS_POINTER)
		|=> coeff_pointer_extended == $past(coeff_pointer_extended)
		&& bit_addr == $past(coeff_pointer_extended) + {{7{$past(operand[15])}}, $past(operand)})
		else $error("constant offset form wrong");
	a_pre_add_wb: assert property (exec && is_bit_op && cmd.mode == bag_pkg::BM_PRE_ADD
		|=> coeff_pointer_extended == $past(sum23) && ($past(circ_enable) || bit_addr == coeff_pointer_extended))
		else $error("pre-add write-back wrong");
	a_parallel_refused: assert property (go && cmd.parallel && uses_k16
		&& !(wr_en && paddr == bag_pkg::OFS_POINTER)
		|=> refused && state == ST_IDLE && $stable(coeff_pointer_extended))
		else $error("paired extended instruction ran");
	a_word_held: assert property (state == ST_XFER && !xfer_ack |=> state == ST_XFER && $stable(xfer))
		else $error("transfer changed before ack");
	a_page_concat: assert property (exec && cmd.op == bag_pkg::OP_PAGE_DIRECT |=>
		xfer.addr == {$past(peripheral_page_pointer), $past(operand[6:0])})
		else $error("page-direct address wrong");
	a_port_route: assert property (exec && cmd.op == bag_pkg::OP_PAGE_DIRECT
		|=> xfer.io_req == $past(cmd.port_qual) && xfer.mem_req != xfer.io_req)
		else $error("port routing wrong");
	a_bit_written: assert property (exec && !cmd.acc_sel && (cmd.op == bag_pkg::OP_BIT_SET
		|| cmd.op == bag_pkg::OP_BIT_CLEAR) |=> accumulator_two[$past(bit_idx)] == ($past(cmd.op) == 3'h0))
		else $error("accumulator bit not written");
	a_linear_addr: assert property (exec && is_bit_op && cmd.mode == bag_pkg::BM_POST_DEC && !circ_enable
		|=> bit_addr == $past(coeff_pointer_extended))
		else $error("linear bit address wrong");
	a_circ_addr: assert property (exec && is_bit_op && cmd.mode == bag_pkg::BM_POST_DEC && circ_enable
		|=> bit_addr[15:0] == $past(coeff_buffer_start) + $past(coeff_pointer_extended[15:0])
		&& bit_addr[22:16] == $past(coeff_pointer_extended[22:16]))
		else $error("circular bit address wrong");

	c_pair_test: cover property (exec && pair);
	c_io_load: cover property (xfer.io_req && !xfer.write && xfer_ack);
	c_refusal: cover property (go && bad);
	c_pre_add_circ: cover property (exec && cmd.mode == bag_pkg::BM_PRE_ADD && circ_enable);
endmodule

/* File: verif/bag_io_model.sv */
// Peripheral register model on the far side of the transfer port
`timescale 1ns/1ps
module bag_io_model
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic slow,
	input bag_pkg::bag_xfer_t xfer,
	output logic xfer_ack,
	output logic [15:0] xfer_rdata,
	output bag_pkg::bag_xfer_t seen
);
	logic [3:0] wait_cnt;
	// Answer each word after a short or long wait; load data is garbled outside the ack cycle
	always_ff @(posedge clock)
	begin
		xfer_ack <= 1'b0;
		xfer_rdata <= ~xfer_rdata;
		if (sys_rst)
		begin
			wait_cnt <= 4'h0;
			xfer_rdata <= 16'h0000;
			seen <= '0;
		end
		else if ((xfer.io_req || xfer.mem_req) && !xfer_ack)
		begin
			wait_cnt <= wait_cnt + 4'h1;
			if (wait_cnt == (slow ? 4'h6 : 4'h0))
			begin
				wait_cnt <= 4'h0;
				xfer_ack <= 1'b1;
				seen <= xfer;
				xfer_rdata <= xfer.addr ^ 16'h5a5a;
			end
		end
	end
endmodule

/* File: verif/bag_addr_gen_bench.sv */
// Self-checking bench of the bit and I/O address generator
`timescale 1ns/1ps
module bag_addr_gen_bench;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic slow = 1'b0;
	logic xfer_ack;
	logic [15:0] xfer_rdata;
	bag_pkg::bag_xfer_t xfer;
	bag_pkg::bag_xfer_t seen;
	int num_errors = 0;
	int tests_run = 0;
	logic [31:0] rd;
	logic err;
	always #4 clock = ~clock;
	bag_addr_gen i_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .xfer(xfer),
		.xfer_ack(xfer_ack), .xfer_rdata(xfer_rdata));
	bag_io_model i_io (.clock(clock), .sys_rst(sys_rst), .slow(slow), .xfer(xfer), .xfer_ack(xfer_ack),
		.xfer_rdata(xfer_rdata), .seen(seen));
	// ****************************************
	// Bus and compare tasks
	// ****************************************
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask
	task automatic xchk(input logic [18:0] e);
		chk("transfer", {13'h0, e}, {13'h0, seen.io_req, seen.mem_req, seen.write, seen.addr});
	endtask
	// Flags are {write, port, parallel, acc}; ends with the idle status word in rd
	task automatic run(input logic [3:0] f, input bag_pkg::bag_mode_t m, input bag_pkg::bag_op_t o,
		input logic [15:0] v);
		int i;
		wr(bag_pkg::OFS_OPERAND, {16'h0, v});
		wr(bag_pkg::OFS_CMD, {23'h0, f, m, o});
		rd = 32'h4;
		for (i = 0; i < 40 && rd[2] !== 1'b0; i++)
			apb(1'b0, bag_pkg::OFS_STATUS, 32'h0);
		chk("busy", 32'h0, {31'h0, rd[2]});
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ****************************************
	// Test sequence
	// ****************************************
	initial
	begin
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		wr(bag_pkg::OFS_ACC_THREE, 32'h0);
		run(4'h1, bag_pkg::BM_POST_DEC, bag_pkg::OP_BIT_SET, 16'h0000);
		rdchk(bag_pkg::OFS_ACC_THREE, 32'h00000001, "acc three");
		rdchk(bag_pkg::OFS_POINTER, 32'h007fffff, "pointer");
		wr(bag_pkg::OFS_ACC_THREE, 32'h40000000);
		wr(bag_pkg::OFS_POINTER, 32'h0000001e);
		run(4'h1, bag_pkg::BM_POST_DEC, bag_pkg::OP_BIT_PAIR_TEST, 16'h0000);
		chk("flags", 32'h1, {30'h0, rd[1:0]});
		rdchk(bag_pkg::OFS_POINTER, 32'h0000001c, "pointer");
		$display("test post decrement finished");
		wr(bag_pkg::OFS_ACC_TWO, 32'hffffffff);
		wr(bag_pkg::OFS_POINTER, 32'h0);
		run(4'h0, bag_pkg::BM_CONST_OFS, bag_pkg::OP_BIT_CLEAR, 16'h001f);
		rdchk(bag_pkg::OFS_ACC_TWO, 32'h7fffffff, "acc two");
		wr(bag_pkg::OFS_POINTER, 32'h1);
		run(4'h0, bag_pkg::BM_CONST_OFS, bag_pkg::OP_BIT_SET, 16'hfffe);
		rdchk(bag_pkg::OFS_BIT_ADDR, 32'h007fffff, "bit address");
		rdchk(bag_pkg::OFS_ACC_TWO, 32'hffffffff, "acc two");
		rdchk(bag_pkg::OFS_POINTER, 32'h1, "pointer");
		wr(bag_pkg::OFS_ACC_TWO, 32'h00400000);
		wr(bag_pkg::OFS_POINTER, 32'h10);
		run(4'h0, bag_pkg::BM_PRE_ADD, bag_pkg::OP_BIT_PAIR_TEST, 16'h0005);
		chk("flags", 32'h2, {30'h0, rd[1:0]});
		rdchk(bag_pkg::OFS_POINTER, 32'h15, "pointer");
		rdchk(bag_pkg::OFS_BIT_ADDR, 32'h15, "bit address");
		$display("test constant offset finished");
		wr(bag_pkg::OFS_CTRL, 32'h1);
		wr(bag_pkg::OFS_BUF_START, 32'h8);
		wr(bag_pkg::OFS_POINTER, 32'h2);
		wr(bag_pkg::OFS_ACC_THREE, 32'h0);
		run(4'h1, bag_pkg::BM_POST_DEC, bag_pkg::OP_BIT_SET, 16'h0000);
		rdchk(bag_pkg::OFS_ACC_THREE, 32'h00000400, "acc three");
		rdchk(bag_pkg::OFS_POINTER, 32'h1, "pointer");
		wr(bag_pkg::OFS_CTRL, 32'h0);
		$display("test circular finished");
		slow <= 1'b1;
		run(4'h0, bag_pkg::BM_POST_DEC, bag_pkg::OP_IO_ABSOLUTE, 16'hf000);
		xchk({3'b100, 16'hf000});
		rdchk(bag_pkg::OFS_IO_DATA, 32'h0000aa5a, "load data");
		slow <= 1'b0;
		wr(bag_pkg::OFS_IO_DATA, 32'h1234);
		run(4'h8, bag_pkg::BM_POST_DEC, bag_pkg::OP_IO_ABSOLUTE, 16'h0002);
		xchk({3'b101, 16'h0002});
		chk("store data", 32'h1234, {16'h0, seen.wdata});
		$display("test absolute finished");
		wr(bag_pkg::OFS_ACC_TWO, 32'h0);
		run(4'h2, bag_pkg::BM_CONST_OFS, bag_pkg::OP_BIT_SET, 16'h0003);
		chk("refused", 32'h1, {31'h0, rd[3]});
		rdchk(bag_pkg::OFS_ACC_TWO, 32'h0, "acc two");
		wr(bag_pkg::OFS_STATUS, 32'h8);
		rdchk(bag_pkg::OFS_STATUS, 32'h00000002, "status");
		run(4'h2, bag_pkg::BM_POST_DEC, bag_pkg::OP_IO_ABSOLUTE, 16'h1357);
		chk("refused", 32'h1, {31'h0, rd[3]});
		xchk({3'b101, 16'h0002});
		wr(bag_pkg::OFS_STATUS, 32'h8);
		$display("test refusal finished");
		wr(bag_pkg::OFS_PAGE, 32'h1ff);
		run(4'h6, bag_pkg::BM_POST_DEC, bag_pkg::OP_PAGE_DIRECT, 16'h0000);
		xchk({3'b100, 16'hff80});
		run(4'hc, bag_pkg::BM_POST_DEC, bag_pkg::OP_PAGE_DIRECT, 16'h007f);
		xchk({3'b101, 16'hffff});
		run(4'h0, bag_pkg::BM_POST_DEC, bag_pkg::OP_PAGE_DIRECT, 16'h0005);
		xchk({3'b010, 16'hff85});
		apb(1'b0, 8'h30, 32'h0);
		chk("slave error", 32'h1, {31'h0, err});
		$display("test page direct finished");
		print_verdict;
	end
	// Watchdog against a hung handshake
	initial
	begin
		#200000;
		num_errors++;
		print_verdict;
	end
endmodule
